// ===== inc/tkd_regs.svh
// Overview of operation
// - Each key output high while active, independent.
// - Report only after six consecutive touch bursts.
// - Stuck key times out, recalibrates, drops output unless in toggle mode.
// - After release and delay, recalibrate again.
// - Max on-duration selects 10s, 60s or infinite.
// - Toggle mode only with 10s on-duration.
// - Fast 40ms or slow 110ms response mode.
// - Spread spectrum and external sync never together.
// - Slow sync mode bursts start on sync fall.
// - Spread varies burst rate about centre, rising.
// - First bursts after reset set each baseline.
// - Baseline drifts slowly toward signal, about 30s.
// - Ready to detect within about 180ms after reset, or after four sync falls in sync mode.
// - Default fast, spread, normal output, 10s.
// - Each LED follows its key output directly.
`ifndef TKD_REGS_SVH
`define TKD_REGS_SVH
`define TKD_CLK_HZ        100000000
`define TKD_FAST_RESP_MS  40
`define TKD_SLOW_RESP_MS  110
`define TKD_DET_COUNT     6
`define TKD_ON_SHORT_S    10
`define TKD_ON_LONG_S     60
`define TKD_RELEASE_S     3
`define TKD_DRIFT_S       30
`define TKD_READY_MS      180
`define TKD_RESET_MIN_MS  1
`define TKD_SPREAD_PCT    7
`define TKD_CAL_BURSTS    4
// Mode codes: 00 fast+spread, 01 fast, 10 slow, 11 slow+sync
`define TKD_MODE_FAST_SS  2'h0
`define TKD_MODE_FAST     2'h1
`define TKD_MODE_SLOW     2'h2
`define TKD_MODE_SYNC     2'h3
// On-duration codes: 00 10s, 01 60s, 10 infinite, 11 toggle+10s
`define TKD_DUR_10        2'h0
`define TKD_DUR_60        2'h1
`define TKD_DUR_INF       2'h2
`define TKD_DUR_TOGGLE    2'h3
`endif

// ===== inc/tkd_pkg.sv
package tkd_pkg;
    // Per-key life cycle
    typedef enum logic [2:0] {
        TKD_CAL    = 3'b000,
        TKD_IDLE   = 3'b001,
        TKD_DET    = 3'b010,
        TKD_STUCK  = 3'b011,
        TKD_RECAL2 = 3'b100
    } tkd_key_e;
endpackage

// ===== hw/tkd_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module tkd_sync2
    import tkd_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;  // First stage, read only by q
    logic [W-1:0] next_s1;
    logic [W-1:0] next_q;

    // ----------------------------------------
    // Two-stage pin synchroniser
    // ----------------------------------------
    always_comb begin
        next_s1 = resetn ? d : '0;
        next_q  = resetn ? s1 : '0;
    end

    always_ff @(posedge mclk) begin
        s1 <= next_s1;
        q  <= next_q;
    end
endmodule
`default_nettype wire

// ===== hw/tkd_key.sv
`timescale 1ns/10ps
`default_nettype none
`include "tkd_regs.svh"
module tkd_key
    import tkd_pkg::*;
#(
    parameter int SW        = 16,
    parameter int BURST_CNT = 6,
    parameter int TW        = 16
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          resetn,
    // Burst results
    input  wire logic          burst_done,
    input  wire logic [SW-1:0] sample,
    input  wire logic [SW-1:0] threshold,
    // Timing ticks and limits in bursts
    input  wire logic          drift_tick,
    input  wire logic [TW-1:0] on_limit,
    input  wire logic          on_inf,
    input  wire logic [TW-1:0] rel_limit,
    input  wire logic          toggle_mode,
    // Status
    output logic               key_out,
    output logic               stuck,
    output logic               cal_done
);
    initial begin
        // The integrator is three bits wide
        if (BURST_CNT < 1 || BURST_CNT > 8 || SW < 2 || TW < 2) $error("tkd_key bad params");
    end

    tkd_key_e      st, next_st;            // Key state
    logic [SW-1:0] base, next_base;        // Baseline reference
    logic [2:0]    integ, next_integ;      // Detect integrator
    logic [TW-1:0] tmr, next_tmr;          // On or release timer
    logic [2:0]    calc, next_calc;        // Calibration burst count
    logic          outq, next_outq;
    logic          touch;

    // Touch when the signal falls below baseline by the threshold
    assign touch    = (base > sample) && ((base - sample) >= threshold);
    assign key_out  = outq;
    assign stuck    = (st == TKD_STUCK);
    assign cal_done = (st != TKD_CAL);

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_st    = st;
        next_base  = base;
        next_integ = integ;
        next_tmr   = tmr;
        next_calc  = calc;
        next_outq  = outq;
        if (burst_done) begin
            case (st)
                TKD_CAL: begin
                    next_base = sample;
                    next_calc = calc + 3'h1;
                    if (calc == 3'(`TKD_CAL_BURSTS - 1)) begin
                        next_st = TKD_IDLE;
                    end
                end
                TKD_IDLE: begin
                    if (touch) begin
                        next_integ = integ + 3'h1;
                        if (integ == 3'(BURST_CNT - 1)) begin
                            next_st    = TKD_DET;
                            next_tmr   = '0;
                            next_integ = '0;
                            next_outq  = toggle_mode ? ~outq : 1'b1;
                        end
                    end else begin
                        next_integ = '0;
                        if (drift_tick && base != sample) begin
                            next_base = (sample > base) ? base + 1'b1 : base - 1'b1;
                        end
                    end
                end
                TKD_DET: begin
                    if (!touch) begin
                        next_st = TKD_IDLE;
                        if (!toggle_mode) next_outq = 1'b0;
                    end else if (!on_inf && tmr >= on_limit) begin
                        next_st   = TKD_STUCK;
                        next_base = sample;
                        next_outq = toggle_mode ? outq : 1'b0;
                        next_tmr  = '0;
                    end else begin
                        next_tmr = tmr + 1'b1;
                    end
                end
                TKD_STUCK: begin
                    next_base = sample;
                    next_tmr  = '0;
                    // Release seen as signal rising well above baseline
                    if ((sample > base) && ((sample - base) >= threshold)) begin
                        next_st = TKD_RECAL2;
                    end
                end
                TKD_RECAL2: begin
                    next_tmr = tmr + 1'b1;
                    if (tmr >= rel_limit) begin
                        next_base = sample;
                        next_st   = TKD_IDLE;
                        next_integ = '0;
                    end
                end
                default: next_st = TKD_CAL;
            endcase
        end
        if (!resetn) begin
            next_st    = TKD_CAL;
            next_base  = '0;
            next_integ = '0;
            next_tmr   = '0;
            next_calc  = '0;
            next_outq  = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        st    <= next_st;
        base  <= next_base;
        integ <= next_integ;
        tmr   <= next_tmr;
        calc  <= next_calc;
        outq  <= next_outq;
    end
endmodule
`default_nettype wire

// ===== hw/tkd_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tkd_regs.svh"
module tkd_top
    import tkd_pkg::*;
#(
    parameter int NKEY     = 4,
    parameter int SW       = 16,
    parameter int CLK_HZ   = `TKD_CLK_HZ,
    // Cycles between burst starts at the centre rate
    parameter int FAST_PER = (`TKD_CLK_HZ / 1000) * `TKD_FAST_RESP_MS / `TKD_DET_COUNT,
    parameter int SLOW_PER = (`TKD_CLK_HZ / 1000) * `TKD_SLOW_RESP_MS / `TKD_DET_COUNT,
    // Drift step spacing, in cycles
    parameter int DRIFT_PER = (`TKD_CLK_HZ / 1000) * 100
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    // Configuration straps, default 00/00
    input  wire logic [1:0]           mode_sel,
    input  wire logic [1:0]           dur_sel,
    // External burst sync pin, falling edge
    input  wire logic                 sync_in,
    // Measured burst results from the analog front end
    input  wire logic [NKEY*SW-1:0]   sample,
    input  wire logic [SW-1:0]        threshold,
    // Burst control toward the front end
    output logic                      burst_start,
    output logic [7:0]                spread_ramp,
    // Key outputs and status
    output logic [NKEY-1:0]           key_out,
    output logic [NKEY-1:0]           led_out,
    output logic [NKEY-1:0]           key_stuck,
    output logic                      ready
);
    localparam int TW  = 16;
    localparam int PW  = 32;
    // Bursts per second follow the real clock and burst period, so a
    // changed period leaves the on and release timeouts the same length in seconds
    localparam int FAST_BPS = CLK_HZ / FAST_PER;
    localparam int SLOW_BPS = CLK_HZ / SLOW_PER;

    initial begin
        if (NKEY < 1 || FAST_PER < 16 || SLOW_PER < 16 || DRIFT_PER < 1)
            $error("tkd_top bad params");
        // Timeout limits must be non-zero and fit the burst timer
        if (CLK_HZ < SLOW_PER || FAST_BPS * `TKD_ON_LONG_S >= 2**TW)
            $error("tkd_top bad clock rate");
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0] pins_s;
    tkd_sync2 #(.W(5)) u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .d      ({sync_in, mode_sel, dur_sel}),
        .q      (pins_s)
    );

    // ----------------------------------------
    // Strap capture after reset release
    // ----------------------------------------
    logic [1:0] mode, next_mode;       // Captured burst mode
    logic [1:0] dur, next_dur;         // Captured on-duration
    logic [1:0] cap_cnt, next_cap_cnt; // Delay until sync chain filled
    logic       sync_d, next_sync_d;   // Previous synced sync level

    // Capture straps once synchroniser is primed
    always_comb begin
        next_mode    = mode;
        next_dur     = dur;
        next_cap_cnt = cap_cnt;
        // Hold the idle level while the synchroniser refills after reset,
        // so a pin already low when the straps are captured is seen as a falling edge
        next_sync_d  = pins_s[4] | (cap_cnt != 2'h3);
        if (cap_cnt != 2'h3) begin
            next_cap_cnt = cap_cnt + 2'h1;
            if (cap_cnt == 2'h2) begin
                next_mode = pins_s[3:2];
                next_dur  = pins_s[1:0];
            end
        end
        if (!resetn) begin
            next_mode    = `TKD_MODE_FAST_SS;
            next_dur     = `TKD_DUR_10;
            next_cap_cnt = 2'h0;
            next_sync_d  = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        mode    <= next_mode;
        dur     <= next_dur;
        cap_cnt <= next_cap_cnt;
        sync_d  <= next_sync_d;
    end

    // spread only in fast, sync only in slow
    logic is_slow, ss_en, sync_en, sync_fall;
    assign is_slow   = mode[1];
    assign ss_en     = (mode == `TKD_MODE_FAST_SS);
    assign sync_en   = (mode == `TKD_MODE_SYNC);
    assign sync_fall = sync_d & ~pins_s[4];

    // ----------------------------------------
    // Burst scheduler with spread ramp
    // ----------------------------------------
    logic [PW-1:0] bcnt, next_bcnt;         // Burst period counter
    logic [7:0]    ramp, next_ramp;         // Sawtooth spread ramp
    logic          bstart, next_bstart;
    logic [PW-1:0] base_per, per;
    logic [PW-1:0] swing;

    assign base_per = is_slow ? PW'(SLOW_PER) : PW'(FAST_PER);
    assign swing = (base_per * PW'(`TKD_SPREAD_PCT)) / PW'(100);
    always_comb begin
        per = base_per;
        if (ss_en) begin
            per = base_per + swing - ((swing * PW'(ramp)) >> 7);
        end
    end

    // Burst launch timing
    always_comb begin
        next_bcnt   = bcnt + 1'b1;
        next_ramp   = ramp;
        next_bstart = 1'b0;
        if (sync_en) begin
            next_bcnt = '0;
            next_bstart = sync_fall;
        end else if (bcnt >= per - 1'b1) begin
            next_bcnt   = '0;
            next_bstart = 1'b1;
            next_ramp   = ss_en ? ramp + 8'h01 : 8'h00;
        end
        if (!resetn) begin
            next_bcnt   = '0;
            next_ramp   = 8'h00;
            next_bstart = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        bcnt   <= next_bcnt;
        ramp   <= next_ramp;
        bstart <= next_bstart;
    end

    assign burst_start = bstart;
    assign spread_ramp = ramp;

    // ----------------------------------------
    // Drift tick generator
    // ----------------------------------------
    logic [PW-1:0] dcnt, next_dcnt;
    logic          dtick, next_dtick;

    always_comb begin
        next_dtick = 1'b0;
        next_dcnt  = dcnt + 1'b1;
        if (dcnt >= PW'(DRIFT_PER - 1)) begin
            next_dcnt  = '0;
            next_dtick = 1'b1;
        end
        if (!resetn) begin
            next_dcnt  = '0;
            next_dtick = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        dcnt  <= next_dcnt;
        dtick <= next_dtick;
    end

    // ----------------------------------------
    // Timeout limits in bursts
    // ----------------------------------------
    logic [TW-1:0] on_limit, rel_limit;
    logic          on_inf, toggle_mode;
    logic [TW-1:0] bps;

    assign bps = is_slow ? TW'(SLOW_BPS) : TW'(FAST_BPS);
    always_comb begin
        case (dur)
            `TKD_DUR_60: on_limit = TW'(bps * TW'(`TKD_ON_LONG_S));
            default:     on_limit = TW'(bps * TW'(`TKD_ON_SHORT_S));
        endcase
    end
    assign on_inf      = (dur == `TKD_DUR_INF);
    assign toggle_mode = (dur == `TKD_DUR_TOGGLE);
    assign rel_limit   = TW'(bps * TW'(`TKD_RELEASE_S));

    // ----------------------------------------
    // Per-key detectors
    // ----------------------------------------
    logic [NKEY-1:0] cal_done;
    genvar k;
    generate
        for (k = 0; k < NKEY; k++) begin : g_key
            tkd_key #(.SW(SW), .BURST_CNT(`TKD_DET_COUNT), .TW(TW)) u_key (
                .mclk        (mclk),
                .resetn      (resetn),
                .burst_done  (bstart),
                .sample      (sample[k*SW +: SW]),
                .threshold   (threshold),
                .drift_tick  (dtick),
                .on_limit    (on_limit),
                .on_inf      (on_inf),
                .rel_limit   (rel_limit),
                .toggle_mode (toggle_mode),
                .key_out     (key_out[k]),
                .stuck       (key_stuck[k]),
                .cal_done    (cal_done[k])
            );
        end
    endgenerate

    assign led_out = key_out;
    assign ready = &cal_done;
endmodule
`default_nettype wire

// ===== bench/tkd_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "tkd_regs.svh"
// ---
// Port checker
// ---
module tkd_properties #(
    parameter int NKEY = 4
) (
    // Clock and reset
    input wire logic            mclk,
    input wire logic            resetn,
    // Straps and sync pin
    input wire logic [1:0]      mode_sel,
    input wire logic [1:0]      dur_sel,
    input wire logic            sync_in,
    // Device outputs
    input wire logic            burst_start,
    input wire logic [7:0]      spread_ramp,
    input wire logic [NKEY-1:0] key_out,
    input wire logic [NKEY-1:0] led_out,
    input wire logic [NKEY-1:0] key_stuck,
    input wire logic            ready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_led_mirror: assert property (led_out == key_out)
        else $error("led_out differs from key_out");
    a_reset_clear: assert property (disable iff (1'b0) !resetn |=> key_out == '0 && !ready)
        else $error("outputs not cleared by reset");
    a_quiet_uncal: assert property (!ready |-> key_out == '0)
        else $error("key reported before calibration");
    a_out_on_burst: assert property ($changed(key_out) |-> $past(burst_start) || $past(burst_start, 2))
        else $error("key_out moved away from a burst");
    a_sync_burst: assert property ($fell(sync_in) && mode_sel == `TKD_MODE_SYNC |-> ##[1:8] burst_start)
        else $error("no burst after sync fall");
    a_ramp_idle: assert property (ready && mode_sel != `TKD_MODE_FAST_SS |-> spread_ramp == 8'h00)
        else $error("spread ramp moving without spread");
    a_burst_gap: assert property (burst_start |=> !burst_start [*8])
        else $error("bursts too close");
    a_stuck_drop: assert property ($rose(key_stuck[0]) && dur_sel != `TKD_DUR_TOGGLE |-> ##[0:2] !key_out[0])
        else $error("stuck key kept its output");
    a_inf_never: assert property (dur_sel == `TKD_DUR_INF |-> key_stuck == '0)
        else $error("stuck flag with infinite on-duration");
    c_stuck: cover property ($rose(key_stuck[0]));
    c_toggle: cover property (dur_sel == `TKD_DUR_TOGGLE && $fell(key_out[0]));
    c_sync: cover property (mode_sel == `TKD_MODE_SYNC && burst_start);
endmodule
bind tkd_top tkd_properties #(.NKEY(NKEY)) u_props (
    .mclk(mclk), .resetn(resetn), .mode_sel(mode_sel), .dur_sel(dur_sel),
    .sync_in(sync_in), .burst_start(burst_start), .spread_ramp(spread_ramp),
    .key_out(key_out), .led_out(led_out), .key_stuck(key_stuck), .ready(ready)
);
`default_nettype wire

// ===== bench/tkd_host.sv
`timescale 1ns/10ps
`default_nettype none
// ---
// Host reading the key lines
// ---
module tkd_host (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Key lines from the device
    input  wire logic [3:0]  key_out,
    // New activations, byte k for key k
    output logic      [31:0] presses
);
    logic [3:0]  prev;         // Lines at the last edge
    logic [31:0] next_presses; // Counts after this edge
    always_comb begin
        next_presses = presses;
        for (int k = 0; k < 4; k++) begin
            if (key_out[k] && !prev[k]) begin
                next_presses[k*8+:8] = presses[k*8+:8] + 8'h01;
            end
        end
    end
    // A reset forgets all history, as a real host would
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            presses <= '0;
            prev    <= '0;
        end else begin
            presses <= next_presses;
            prev    <= key_out;
        end
    end
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "tkd_regs.svh"
module tb;
    // ---
    // Stimulus and wiring
    // ---
    typedef struct packed {
        logic [3:0] touch;  // Keys held
        logic [3:0] bursts; // Bursts to run
        logic [3:0] exp;    // Lines expected after
    } tkd_row_s;
    tkd_row_s rows [10] = '{'{4'h1, 4'd5, 4'h0}, '{4'h1, 4'd1, 4'h1}, '{4'h0, 4'd1, 4'h0},
        '{4'h2, 4'd3, 4'h0}, '{4'h0, 4'd1, 4'h0}, '{4'h2, 4'd5, 4'h0}, '{4'ha, 4'd1, 4'h2},
        '{4'ha, 4'd5, 4'ha}, '{4'h4, 4'd6, 4'h4}, '{4'h0, 4'd1, 4'h0}};
    int          lo [3] = '{29, 32, 64}; // Shortest gap per mode
    int          hi [3] = '{35, 32, 64}; // Longest gap per mode
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [1:0]  mode_sel = 2'h0;
    logic [1:0]  dur_sel = 2'h0;
    logic        sync_in = 1'b1;
    logic        sync_run = 1'b0; // Toggle sync freely
    logic [63:0] sample = {4{16'h1000}};
    logic [15:0] threshold = 16'h0040;
    logic        burst_start;
    logic [7:0]  spread_ramp;
    logic [3:0]  key_out;
    logic [3:0]  led_out;
    logic [3:0]  key_stuck;
    logic        ready;
    logic [31:0] presses;
    logic        seen;
    int          c;
    int          miscompares = 0;
    int          total_checks = 0;
    // A low clock rate keeps the stuck timeout within a few thousand cycles
    tkd_top #(.CLK_HZ(640), .FAST_PER(32), .SLOW_PER(64), .DRIFT_PER(64)) uut (
        .mclk(mclk), .resetn(resetn), .mode_sel(mode_sel), .dur_sel(dur_sel),
        .sync_in(sync_in), .sample(sample), .threshold(threshold),
        .burst_start(burst_start), .spread_ramp(spread_ramp), .key_out(key_out),
        .led_out(led_out), .key_stuck(key_stuck), .ready(ready)
    );
    tkd_host u_host (.mclk(mclk), .resetn(resetn), .key_out(key_out), .presses(presses));
    always #5 mclk = ~mclk;
    always @(negedge mclk) begin
        if (sync_run) begin
            sync_in <= ~sync_in;
        end
    end
    // ---
    // Tasks
    // ---
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic set_touch(input logic [3:0] m);
        for (int k = 0; k < 4; k++) begin
            sample[k*16+:16] = m[k] ? 16'h0e00 : 16'h1000;
        end
    endtask
    // Counts burst pulses at settled falling edges, then lets outputs land
    task automatic wait_bursts(input int n);
        int t;
        t = 0;
        while (n > 0 && t < 20000) begin
            @(negedge mclk);
            t++;
            if (burst_start === 1'b1) n--;
        end
        chk_bit("burst seen", 1'b1, n == 0);
        if (n > 0) final_report();
        repeat (2) @(negedge mclk);
    endtask
    task automatic step(input logic [3:0] m, input logic [3:0] n, input logic [3:0] e);
        set_touch(m);
        wait_bursts(int'(n));
        chk_val("key_out", 32'(e), 32'(key_out));
        chk_val("led_out", 32'(e), 32'(led_out));
    endtask
    task automatic wait_flag(input logic v);
        int t;
        t = 0;
        while (key_stuck[0] !== v && t < 20000) begin
            @(negedge mclk);
            t++;
        end
        chk_bit("key_stuck", v, key_stuck[0]);
        if (key_stuck[0] !== v) final_report();
    endtask
    task automatic do_reset(input logic [1:0] m, input logic [1:0] d, input bit w);
        int t;
        @(negedge mclk);
        mode_sel = m;
        dur_sel = d;
        resetn = 1'b0;
        repeat (2) @(negedge mclk);
        chk_val("key_out", 32'h0, 32'(key_out));
        chk_bit("ready", 1'b0, ready);
        resetn = 1'b1;
        t = 0;
        while (w && ready !== 1'b1 && t < 800) begin
            @(negedge mclk);
            t++;
        end
        if (w) chk_bit("ready", 1'b1, ready);
        if (w && ready !== 1'b1) final_report();
    endtask
    // ---
    // Sequence
    // ---
    initial begin
        do_reset(`TKD_MODE_FAST_SS, `TKD_DUR_10, 1'b1);
        foreach (rows[i]) step(rows[i].touch, rows[i].bursts, rows[i].exp);
        chk_val("presses", 32'h01010101, presses);
        $display("test rows done");
        set_touch(4'h1);
        do_reset(`TKD_MODE_FAST_SS, `TKD_DUR_10, 1'b1);
        step(4'h1, 4'd6, 4'h0);
        set_touch(4'h0);
        $display("test calibration done");
        do_reset(`TKD_MODE_FAST_SS, `TKD_DUR_TOGGLE, 1'b1);
        step(4'h1, 4'd6, 4'h1);
        step(4'h0, 4'd1, 4'h1);
        step(4'h1, 4'd6, 4'h0);
        set_touch(4'h0);
        $display("test toggle done");
        for (int m = 0; m < 3; m++) begin
            do_reset(2'(m), `TKD_DUR_INF, 1'b1);
            sync_run = (m != 0);
            c = 0;
            while (burst_start !== 1'b1 && c < 500) begin @(negedge mclk); c++; end
            c = 0;
            do begin @(negedge mclk); c++; end while (burst_start !== 1'b1 && c < 500);
            chk_bit("burst gap", 1'b1, c >= lo[m] && c <= hi[m]);
            seen = 1'b0;
            repeat (400) begin @(negedge mclk); seen |= (spread_ramp != 8'h00); end
            chk_bit("ramp moving", m == 0, seen);
        end
        sync_run = 1'b0;
        // Let the free-running toggle see the stop before parking the pin
        @(negedge mclk);
        sync_in = 1'b1;
        $display("test modes done");
        do_reset(`TKD_MODE_SYNC, `TKD_DUR_10, 1'b0);
        c = 0;
        repeat (200) begin @(negedge mclk); c += int'(burst_start); end
        chk_val("bursts unsynced", 32'h0, 32'(c));
        for (int i = 0; i < 6; i++) begin
            sync_in = 1'b0;
            repeat (10) begin @(negedge mclk); c += int'(burst_start); end
            sync_in = 1'b1;
            repeat (40) @(negedge mclk);
        end
        chk_val("bursts synced", 32'h6, 32'(c));
        chk_bit("ready", 1'b1, ready);
        $display("test sync done");
        do_reset(`TKD_MODE_FAST, `TKD_DUR_10, 1'b1);
        set_touch(4'h1);
        wait_flag(1'b1);
        chk_val("key_out", 32'h0, 32'(key_out));
        set_touch(4'h0);
        wait_flag(1'b0);
        wait_bursts(120);
        step(4'h1, 4'd6, 4'h1);
        $display("test stuck done");
        final_report();
    end
endmodule
`default_nettype wire
